// File: rtl/bcs_sequencer.sv
// soft-start, power-good, fault latch and conduction mode sequencer
// Behaviour
// RULE_01: ramp output to setpoint in about 1.5 ms
// RULE_02: reference steps from 0 to 600 mV
// RULE_03: start after bias rises from below falling threshold
// RULE_04: enable starts ramp and power-good delay
// RULE_05: enable low stops switching and bias at once
// RULE_06: faults clear only after bias under falling threshold; the code also clears the fault latch when enable is low
// RULE_07: power-good undefined before bias is valid
// RULE_08: power-good has three selectable pull-downs
// RULE_09: strengths: off open, ramp/UV 95, OV 60, OC 30
// RULE_10: high side waits for low gate below 1 V
// RULE_11: low side waits for high gate below 1 V
// RULE_12: positive switch node means negative current
// RULE_13: continuous mode drives low side every cycle
// RULE_14: diode emulation keeps low side off on negative current
// RULE_15: system drives mode select low or high
// RULE_16: eight positive readings enter diode emulation next cycle
// RULE_17: one negative reading exits emulation next pulse
// RULE_18: force pulses to stay above audible range
// RULE_19: pulse edges follow the window comparator
// RULE_20: faults latch off until enable or bias drops
// RULE_21: positive counter clears on negative, disable, bias reset
`timescale 1ns/1ps
module bcs_sequencer
   import bcs_pkg::*;
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   // enable and bias supply comparators
   input  wire logic       enable_in,
   input  wire logic       bias_above_rising_in,
   input  wire logic       bias_below_falling_in,
   // fault comparators
   input  wire logic       undervoltage_in,
   input  wire logic       overvoltage_in,
   input  wire logic       overcurrent_in,
   input  wire logic       short_circuit_in,
   // modulator and mode inputs
   input  wire logic       window_comp_in,
   input  wire logic       continuous_mode_select_in,
   input  wire logic       switch_node_positive_in,
   // gate voltage sense, high when below 1 V
   input  wire logic       high_gate_low_in,
   input  wire logic       low_gate_low_in,
   // gate commands
   output logic            high_side_gate_out,
   output logic            low_side_gate_out,
   // power-good pull-down enables and bias regulator control
   output logic [2:0]      power_good_out_oe,
   output logic            power_good_out,
   output logic            bias_regulate_out,
   // status
   output logic [9:0]      reference_mv_out,
   output logic            diode_emulation_out,
   output logic [4:0]      state_out
);
   typedef struct packed {
      bcs_state_t  state;
      bcs_fault_t  fault;
      logic        armed;       // bias has been below falling threshold
      logic        en_prev;
      logic [9:0]  ref_mv;
      logic [4:0]  step_cnt;
      logic        ss_done;
      logic        win_prev;
      logic        pwm;
      logic [3:0]  pos_cnt;
      logic        diode_em;
      logic [8:0]  gap_cnt;
      logic [3:0]  force_cnt;
      logic        forcing;
      logic [2:0]  pd;
   } bcs_seq_t;

   bcs_seq_t st_r;
   bcs_seq_t st_nxt;
   logic     pulse_start;
   logic     pulse_end;
   logic     high_req;
   logic     low_req;
   logic     any_fault;

   // pulse edges from the hysteretic window comparator
   assign pulse_start = window_comp_in && !st_r.win_prev; // see RULE_19
   assign pulse_end   = !window_comp_in && st_r.win_prev; // see RULE_19
   assign any_fault   = undervoltage_in | overvoltage_in | overcurrent_in | short_circuit_in;

   // next-state logic
   always_comb begin
      st_nxt          = st_r;
      st_nxt.en_prev  = enable_in;
      st_nxt.win_prev = window_comp_in;
      if (bias_below_falling_in) begin
         st_nxt.armed = 1'b1;
      end
      case (st_r.state)
         BCS_OFF: begin
            st_nxt.ref_mv   = REF_ZERO;
            st_nxt.step_cnt = '0;
            st_nxt.ss_done  = 1'b0;
            // start after a fresh rise and an enable edge
            if (st_r.armed && bias_above_rising_in && enable_in && !st_r.en_prev) begin
               st_nxt.state = BCS_RAMP; // see RULE_03, RULE_04
               st_nxt.armed = 1'b0;
            end
         end
         BCS_RAMP: begin
            // stepped reference from 0 to 600 mV
            if (st_r.step_cnt == REF_STEP_LAST) begin
               st_nxt.step_cnt = '0;
               if (st_r.ref_mv == REF_TARGET) begin
                  st_nxt.ss_done = 1'b1;
                  st_nxt.state   = BCS_RUN; // see RULE_01, RULE_04
               end else begin
                  st_nxt.ref_mv = st_r.ref_mv + 10'h001; // see RULE_02
               end
            end else begin
               st_nxt.step_cnt = st_r.step_cnt + 5'h01;
            end
            if (any_fault) begin
               st_nxt.state = BCS_FAULT;
            end
         end
         BCS_RUN: begin
            if (any_fault) begin
               st_nxt.state = BCS_FAULT; // see RULE_20
            end
         end
         BCS_FAULT: begin
            st_nxt.state = BCS_FAULT; // latched, see RULE_20
         end
         BCS_IDLE: begin
            st_nxt.state = BCS_OFF;
         end
         default: begin
            st_nxt.state = BCS_OFF;
         end
      endcase
      // latch the worst fault seen, current beats over beats under
      if ((st_r.state == BCS_RAMP) || (st_r.state == BCS_RUN) || (st_r.state == BCS_FAULT)) begin
         if (overcurrent_in || short_circuit_in) begin
            st_nxt.fault = FLT_CURRENT;
         end else if (overvoltage_in && (st_r.fault != FLT_CURRENT)) begin
            st_nxt.fault = FLT_OVER;
         end else if (undervoltage_in && (st_r.fault == FLT_NONE)) begin
            st_nxt.fault = FLT_UNDER;
         end
      end
      // enable low stops at once; bias drop clears latches
      if (!enable_in) begin
         st_nxt.state = BCS_OFF; // see RULE_05, RULE_20
         st_nxt.fault = FLT_NONE;
      end
      if (bias_below_falling_in) begin
         st_nxt.state = BCS_OFF; // see RULE_06
         st_nxt.fault = FLT_NONE;
         st_nxt.armed = 1'b1; // set wins over a start in the same cycle, see RULE_03
      end

      // pwm pulse follows comparator, audio filter inserts pulses
      if (pulse_start) begin
         st_nxt.pwm     = 1'b1;
         st_nxt.gap_cnt = '0;
         st_nxt.forcing = 1'b0;
      end else if (pulse_end && !st_r.forcing) begin
         st_nxt.pwm = 1'b0;
      end else if (st_r.forcing) begin
         if (st_r.force_cnt == FORCE_ON_LAST) begin
            st_nxt.pwm     = 1'b0;
            st_nxt.forcing = 1'b0;
         end else begin
            st_nxt.force_cnt = st_r.force_cnt + 4'h1;
         end
      end else if (st_r.pwm) begin
         st_nxt.gap_cnt = '0; // gap counted from pulse end, long pulses stay whole
      end else if (st_r.gap_cnt == AUDIO_GAP_LAST) begin
         st_nxt.pwm       = 1'b1; // see RULE_18
         st_nxt.forcing   = 1'b1;
         st_nxt.force_cnt = '0;
         st_nxt.gap_cnt   = '0;
      end else begin
         st_nxt.gap_cnt = st_r.gap_cnt + 9'h001;
      end

      // switch node polarity sampled when a new pulse begins
      if (st_r.pwm && !st_nxt.pwm) begin
         // nothing at pulse end; reading taken at low-side conduction
      end
      if (!st_r.pwm && st_nxt.pwm && low_side_gate_out) begin
         if (switch_node_positive_in) begin // negative current, see RULE_12
            if (st_r.pos_cnt != POS_COUNT_NEED) begin
               st_nxt.pos_cnt = st_r.pos_cnt + 4'h1;
            end
            if (st_r.pos_cnt == (POS_COUNT_NEED - 4'h1)) begin
               st_nxt.diode_em = !continuous_mode_select_in; // see RULE_16
            end
         end else begin
            st_nxt.pos_cnt  = POS_COUNT_ZERO; // see RULE_21
            st_nxt.diode_em = 1'b0; // see RULE_17
         end
      end
      // forced continuous, disabled, bias-low or off converter leaves emulation; a latched fault keeps it
      if (continuous_mode_select_in) begin
         st_nxt.diode_em = 1'b0;
      end
      if (!enable_in || bias_below_falling_in || (st_r.state == BCS_OFF)) begin
         st_nxt.pos_cnt  = POS_COUNT_ZERO; // see RULE_21
         st_nxt.diode_em = 1'b0;
      end

      // pull-down strength select
      st_nxt.pd = 3'h0;
      if (st_nxt.state == BCS_RAMP) begin
         st_nxt.pd[PD_95_OHM] = 1'b1; // see RULE_09
      end else if (st_nxt.state == BCS_FAULT) begin
         case (st_nxt.fault)
            FLT_CURRENT: st_nxt.pd[PD_30_OHM] = 1'b1;
            FLT_OVER:    st_nxt.pd[PD_60_OHM] = 1'b1;
            FLT_UNDER:   st_nxt.pd[PD_95_OHM] = 1'b1;
            default:     st_nxt.pd[PD_95_OHM] = 1'b1;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         st_r       <= '0;
         st_r.state <= BCS_OFF;
         st_r.fault <= FLT_NONE;
         st_r.armed <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // gate requests: switching only while ramping or running
   always_comb begin
      high_req = 1'b0;
      low_req  = 1'b0;
      // enable or bias loss drops both requests in the same cycle
      if (((st_r.state == BCS_RAMP) || (st_r.state == BCS_RUN)) && enable_in
          && !bias_below_falling_in) begin // see RULE_05
         high_req = st_r.pwm;
         // emulation blocks low side on negative current
         low_req  = !st_r.pwm && !(st_r.diode_em && switch_node_positive_in); // see RULE_13, RULE_14
      end
   end

   // shoot-through interlock
   bcs_gate_interlock u_interlock (
      .clock_in           (clock_in),
      .rst_n_in           (rst_n_in),
      .high_req_in        (high_req),
      .low_req_in         (low_req),
      .high_gate_low_in   (high_gate_low_in),
      .low_gate_low_in    (low_gate_low_in),
      .high_side_gate_out (high_side_gate_out),
      .low_side_gate_out  (low_side_gate_out)
   );

   // three open-drain pull-downs; pin level is always low when driving
   assign power_good_out_oe   = st_r.pd; // see RULE_08, RULE_07
   assign power_good_out      = 1'b0;
   assign bias_regulate_out   = enable_in; // see RULE_05
   assign reference_mv_out    = st_r.ref_mv;
   assign diode_emulation_out = st_r.diode_em;
   assign state_out           = st_r.state;
endmodule

// File: rtl/bcs_pkg.sv
// constants and types shared by the buck control sequencer
package bcs_pkg;
   // clock
   localparam int unsigned CLK_HZ          = 10_000_000;
   // soft-start ramp time in microseconds
   localparam int unsigned SS_TIME_US      = 1500;
   localparam int unsigned SS_CYCLES       = (SS_TIME_US * (CLK_HZ / 1_000_000));
   // reference reaches 600 mV in millivolt steps
   localparam int unsigned REF_TARGET_MV   = 600;
   localparam int unsigned REF_START_MV    = 0;
   localparam int unsigned REF_STEP_CYC    = SS_CYCLES / REF_TARGET_MV;
   localparam logic [9:0]  REF_TARGET      = 10'h258;
   localparam logic [9:0]  REF_ZERO        = 10'h000;
   localparam logic [4:0]  REF_STEP_LAST   = 5'(REF_STEP_CYC - 1);
   // audible floor: longest gap between pulses, microseconds
   localparam int unsigned AUDIO_GAP_US    = 40;
   localparam int unsigned AUDIO_GAP_CYC   = AUDIO_GAP_US * (CLK_HZ / 1_000_000);
   localparam logic [8:0]  AUDIO_GAP_LAST  = 9'(AUDIO_GAP_CYC - 1);
   // forced pulse length, microseconds
   localparam int unsigned FORCE_ON_US     = 1;
   localparam int unsigned FORCE_ON_CYC    = FORCE_ON_US * (CLK_HZ / 1_000_000);
   localparam logic [3:0]  FORCE_ON_LAST   = 4'(FORCE_ON_CYC - 1);
   // positive readings needed before diode emulation
   localparam logic [3:0]  POS_COUNT_NEED  = 4'h8;
   localparam logic [3:0]  POS_COUNT_ZERO  = 4'h0;
   // power-good pull-down selects: index of each strength
   localparam int unsigned PD_95_OHM       = 0;
   localparam int unsigned PD_60_OHM       = 1;
   localparam int unsigned PD_30_OHM       = 2;
   localparam int unsigned PD_COUNT        = 3;

   // sequencer states, one-hot
   typedef enum logic [4:0] {
      BCS_OFF     = 5'h01,
      BCS_RAMP    = 5'h02,
      BCS_RUN     = 5'h04,
      BCS_FAULT   = 5'h08,
      BCS_IDLE    = 5'h10
   } bcs_state_t;

   // latched fault kinds
   typedef enum logic [3:0] {
      FLT_NONE    = 4'h1,
      FLT_UNDER   = 4'h2,
      FLT_OVER    = 4'h4,
      FLT_CURRENT = 4'h8
   } bcs_fault_t;
endpackage

// File: rtl/bcs_gate_interlock.sv
// dead-time interlock between the high-side and low-side gate commands
`timescale 1ns/1ps
module bcs_gate_interlock
   import bcs_pkg::*;
(
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   // requested gate states
   input  wire logic high_req_in,
   input  wire logic low_req_in,
   // gate voltage sense, high when gate is below 1 V
   input  wire logic high_gate_low_in,
   input  wire logic low_gate_low_in,
   // gate commands
   output logic      high_side_gate_out,
   output logic      low_side_gate_out
);
   typedef struct packed {
      logic high_r;
      logic low_r;
   } bcs_gil_t;

   bcs_gil_t st_r;
   bcs_gil_t st_nxt;

   // each side waits for the other gate to be discharged
   always_comb begin
      st_nxt = st_r;
      if (!high_req_in) begin
         st_nxt.high_r = 1'b0;
      end else if (!st_r.low_r && !low_req_in && low_gate_low_in) begin
         st_nxt.high_r = 1'b1; // see RULE_10
      end
      if (!low_req_in) begin
         st_nxt.low_r = 1'b0;
      end else if (!st_r.high_r && !high_req_in && high_gate_low_in) begin
         st_nxt.low_r = 1'b1; // see RULE_11
      end
   end

   // state register
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign high_side_gate_out = st_r.high_r;
   assign low_side_gate_out  = st_r.low_r;
endmodule

// File: testbench/bcs_stage_model.sv
// power stage and supervisor model: gate discharge sense and pulled-up power-good pin
`timescale 1ns/1ps
module bcs_stage_model
   import bcs_pkg::*;
(
   // clock and speed
   input  wire logic       clock_in,
   input  wire logic       slow_in,
   // gate commands and pull-down enables
   input  wire logic       high_side_gate_in,
   input  wire logic       low_side_gate_in,
   input  wire logic [2:0] power_good_oe_in,
   // sensed levels
   output logic            high_gate_low_out,
   output logic            low_gate_low_out,
   output logic            power_good_level_out
);
   int hcnt = 9;
   int lcnt = 9;
   // gate reads low only some cycles after its command drops
   always @(posedge clock_in) begin
      hcnt <= high_side_gate_in ? 0 : hcnt + 1;
      lcnt <= low_side_gate_in ? 0 : lcnt + 1;
   end
   assign high_gate_low_out = hcnt >= (slow_in ? 4 : 1);
   assign low_gate_low_out  = lcnt >= (slow_in ? 4 : 1);
   // pull-up wins only when no pull-down is on
   assign power_good_level_out = ~|power_good_oe_in;
endmodule

// File: testbench/bcs_sequencer_chk.sv
// assertion checker bound to the sequencer ports
`timescale 1ns/1ps
module bcs_sequencer_chk
   import bcs_pkg::*;
(
   // clock, reset and supply inputs
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       enable_in,
   input wire logic       bias_below_falling_in,
   // fault and mode inputs
   input wire logic       undervoltage_in,
   input wire logic       overvoltage_in,
   input wire logic       overcurrent_in,
   input wire logic       short_circuit_in,
   input wire logic       continuous_mode_select_in,
   // gate sense and commands
   input wire logic       high_gate_low_in,
   input wire logic       low_gate_low_in,
   input wire logic       high_side_gate_out,
   input wire logic       low_side_gate_out,
   input wire logic       bias_regulate_out,
   // power-good and status
   input wire logic [2:0] power_good_out_oe,
   input wire logic [9:0] reference_mv_out,
   input wire logic       diode_emulation_out,
   input wire logic [4:0] state_out
);
   logic live;
   logic hard;
   // converter active and not being shut down
   assign live = (state_out == BCS_RAMP || state_out == BCS_RUN) && enable_in
                 && !bias_below_falling_in;
   assign hard = overcurrent_in || short_circuit_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_gates_apart: assert property (!(high_side_gate_out && low_side_gate_out))
      else $error("both gates on");
   a_high_waits: assert property ($rose(high_side_gate_out) |->
      $past(low_gate_low_in) && !$past(low_side_gate_out)) else $error("high gate early");
   a_low_waits: assert property ($rose(low_side_gate_out) |->
      $past(high_gate_low_in) && !$past(high_side_gate_out)) else $error("low gate early");
   a_ramp_pull: assert property (state_out == BCS_RAMP |-> power_good_out_oe == 3'h1)
      else $error("ramp pull-down wrong");
   a_quiet_open: assert property (state_out == BCS_OFF || state_out == BCS_RUN |->
      power_good_out_oe == 3'h0) else $error("power good not open");
   a_oc_code: assert property (live && hard |=>
      state_out == BCS_FAULT && power_good_out_oe == 3'h4) else $error("current fault code");
   a_ov_code: assert property (live && !hard && overvoltage_in |=>
      state_out == BCS_FAULT && power_good_out_oe == 3'h2) else $error("over fault code");
   a_uv_code: assert property (live && !hard && !overvoltage_in && undervoltage_in |=>
      state_out == BCS_FAULT && power_good_out_oe == 3'h1) else $error("under fault code");
   a_fault_hold: assert property (state_out == BCS_FAULT && enable_in
      && !bias_below_falling_in |=> state_out == BCS_FAULT) else $error("fault released");
   a_enable_off: assert property (!enable_in |=> state_out == BCS_OFF)
      else $error("not off after disable");
   a_stop_fast: assert property (!enable_in |=>
      !high_side_gate_out && !low_side_gate_out) else $error("gates on after disable");
   a_bias_reg: assert property (bias_regulate_out == enable_in)
      else $error("bias regulator control");
   a_bias_clear: assert property (bias_below_falling_in |=> state_out == BCS_OFF)
      else $error("not off after bias low");
   a_ref_step: assert property (state_out == BCS_RAMP && $past(state_out) == BCS_RAMP |->
      reference_mv_out == $past(reference_mv_out)
      || reference_mv_out == $past(reference_mv_out) + 10'h1) else $error("ramp step");
   a_run_ref: assert property (state_out == BCS_RUN |-> reference_mv_out == REF_TARGET)
      else $error("run reference");
   a_dem_select: assert property ($rose(diode_emulation_out) |->
      !$past(continuous_mode_select_in)) else $error("emulation while forced");
endmodule

bind bcs_sequencer bcs_sequencer_chk u_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
   .bias_below_falling_in(bias_below_falling_in), .undervoltage_in(undervoltage_in),
   .overvoltage_in(overvoltage_in), .overcurrent_in(overcurrent_in),
   .short_circuit_in(short_circuit_in),
   .continuous_mode_select_in(continuous_mode_select_in),
   .high_gate_low_in(high_gate_low_in), .low_gate_low_in(low_gate_low_in),
   .high_side_gate_out(high_side_gate_out), .low_side_gate_out(low_side_gate_out),
   .bias_regulate_out(bias_regulate_out), .power_good_out_oe(power_good_out_oe),
   .reference_mv_out(reference_mv_out), .diode_emulation_out(diode_emulation_out),
   .state_out(state_out));

// File: testbench/buck_controller_sequencer_bench.sv
// self-checking bench for the buck control sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module buck_controller_sequencer_bench
   import bcs_pkg::*;
;
   // stimulus and observed signals
   logic       clock_in = 1'b0;
   logic       rst_n = 1'b0, en = 1'b0, ba = 1'b1, bb = 1'b0, win = 1'b0;
   logic       cms = 1'b1, sn = 1'b0, slow = 1'b0;
   logic [3:0] flt = 4'h0;
   logic       hgl, lgl, hg, lg, pgv, pgo, breg, diode_emulation;
   logic [2:0] oe;
   logic [9:0] ref_mv;
   logic [4:0] st;
   logic       hi_seen, hi_late, lo_seen;
   int         n_errors = 0, samples_checked = 0, cycles = 0;

   always #50 clock_in = ~clock_in;

   bcs_sequencer dut (.clock_in(clock_in), .rst_n_in(rst_n), .enable_in(en),
      .bias_above_rising_in(ba), .bias_below_falling_in(bb), .undervoltage_in(flt[0]),
      .overvoltage_in(flt[1]), .overcurrent_in(flt[2]), .short_circuit_in(flt[3]),
      .window_comp_in(win), .continuous_mode_select_in(cms), .switch_node_positive_in(sn),
      .high_gate_low_in(hgl), .low_gate_low_in(lgl), .high_side_gate_out(hg),
      .low_side_gate_out(lg), .power_good_out_oe(oe), .power_good_out(pgo),
      .bias_regulate_out(breg), .reference_mv_out(ref_mv), .diode_emulation_out(diode_emulation),
      .state_out(st));
   bcs_stage_model stage (.clock_in(clock_in), .slow_in(slow), .high_side_gate_in(hg),
      .low_side_gate_in(lg), .power_good_oe_in(oe), .high_gate_low_out(hgl),
      .low_gate_low_out(lgl), .power_good_level_out(pgv));

   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic tick(int n);
      repeat (n) @(negedge clock_in);
   endtask
   // one window pulse, then watch the gates settle
   task automatic pulse(int len);
      int i;
      {hi_seen, hi_late, lo_seen} = 3'h0;
      win = 1'b1;
      for (i = 0; i < len + 40; i++) begin
         tick(1);
         if (i == len) win = 1'b0;
         if (i < len) hi_seen |= hg;
         if (i > len + 8) begin
            hi_late |= hg;
            lo_seen |= lg;
         end
      end
   endtask
   task automatic t_reset();
      `CHK("state", BCS_OFF, st)
      `CHK("pull-downs", 3'h0, oe)
      `CHK("gates", 2'h0, {hg, lg})
      `CHK("pin level", 1'b1, pgv)
      `CHK("pin drive", 1'b0, pgo)
   endtask
   task automatic t_ramp();
      int n;
      en = 1'b1;
      tick(1);
      `CHK("state", BCS_RAMP, st)
      `CHK("pull-downs", 3'h1, oe)
      `CHK("pin level", 1'b0, pgv)
      `CHK("bias reg on", 1'b1, breg)
      tick(7000);
      `CHK("mid ramp", 1'b1, ref_mv > 10'h0 && ref_mv < REF_TARGET)
      for (n = 7001; n < 20000 && st !== BCS_RUN; n++) tick(1);
      `CHK("ramp length", 1'b1, n > 14000 && n < 17000)
      `CHK("reference", REF_TARGET, ref_mv)
      `CHK("pull-downs", 3'h0, oe)
   endtask
   task automatic t_pwm();
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         pulse(20);
         `CHK("high on", 1'b1, hi_seen)
         `CHK("high ends", 1'b0, hi_late)
         `CHK("low on", 1'b1, lo_seen)
      end
   endtask
   task automatic t_dem();
      sn = 1'b1;
      repeat (9) pulse(20);
      `CHK("forced", 1'b0, diode_emulation)
      cms = 1'b0;
      sn = 1'b0;
      pulse(20);
      sn = 1'b1;
      repeat (7) pulse(20);
      `CHK("seven", 1'b0, diode_emulation)
      pulse(20);
      `CHK("eight", 1'b1, diode_emulation)
      pulse(20);
      `CHK("low blocked", 1'b0, lo_seen)
      sn = 1'b0;
      repeat (2) pulse(20);
      `CHK("exit", 1'b0, diode_emulation)
      sn = 1'b1;
      repeat (7) pulse(20);
      `CHK("count cleared", 1'b0, diode_emulation)
      pulse(20);
      `CHK("count refilled", 1'b1, diode_emulation)
      sn = 1'b0;
      cms = 1'b1;
   endtask
   task automatic t_audio();
      int n;
      for (n = 0; n < 1000 && hg !== 1'b1; n++) tick(1);
      `CHK("forced pulse", 1'b1, n > 250 && n < AUDIO_GAP_CYC + 20)
      tick(30);
      `CHK("forced ends", 1'b0, hg)
   endtask
   task automatic t_faults();
      logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
      for (int k = 0; k < 4; k++) begin
         en = 1'b0;
         bb = 1'b1;
         tick(2);
         `CHK("gates off", 2'h0, {hg, lg})
         bb = 1'b0;
         tick(1);
         en = 1'b1;
         tick(1);
         `CHK("restart", BCS_RAMP, st)
         tick(5);
         flt = 4'h1 << k;
         tick(1);
         `CHK("latched", BCS_FAULT, st)
         `CHK("fault code", code[k], oe)
         flt = 4'h0;
         tick(20);
         `CHK("still latched", BCS_FAULT, st)
         `CHK("high off", 1'b0, hg)
      end
      en = 1'b0;
      tick(1);
      `CHK("bias reg", 1'b0, breg)
      `CHK("off", BCS_OFF, st)
      `CHK("pin level", 1'b1, pgv)
      en = 1'b1;
      tick(2);
      `CHK("no rearm", BCS_OFF, st)
      bb = 1'b1;
      tick(1);
      bb = 1'b0;
      en = 1'b0;
      tick(1);
      en = 1'b1;
      tick(1);
      `CHK("rearmed", BCS_RAMP, st)
      bb = 1'b1;
      tick(1);
      `CHK("bias drop", BCS_OFF, st)
   endtask
   // main sequence
   initial begin
      tick(8);
      rst_n = 1'b1;
      tick(1);
      t_reset();
      t_ramp();
      t_pwm();
      t_dem();
      t_audio();
      t_faults();
      close_out();
   end
endmodule
